// File: tsc_client.sv
// Two-wire serial client of the touch sensor controller
module tsc_client
    import tsc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TSC_SCL_LOW_TIMEOUT_CYC,
    parameter int unsigned IDLE_CYCLES    = TSC_BUS_IDLE_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       serial_clock_pin_i,
    input  wire logic       sda_i,
    input  wire logic       timeout_enable_i,
    input  wire logic       deep_sleep_control_i,
    input  wire logic [7:0] rd_data_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            wr_en_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      wr_data_o,
    output logic            wake_o
);
    localparam int unsigned TMR_MAX = ((TIMEOUT_CYCLES > IDLE_CYCLES) ? TIMEOUT_CYCLES : IDLE_CYCLES) + 2;
    localparam int unsigned TW      = $clog2(TMR_MAX + 1);

    logic          link_bit;
    logic          link_tgl;
    logic          scl_s;
    logic          sda_s;
    logic          tgl_s;
    logic          scl_d;
    logic          sda_d;
    logic          tgl_d;
    logic          start_ev;
    logic          stop_ev;
    logic          scl_fall;
    logic          bit_ev;
    logic          bus_reset;
    logic [7:0]    full_byte;

    tsc_state_type state;
    tsc_state_type next_state;
    logic [2:0]    cnt;
    logic [2:0]    next_cnt;
    logic [7:0]    shreg;
    logic [7:0]    next_shreg;
    logic [7:0]    tx;
    logic [7:0]    next_tx;
    logic [7:0]    next_ptr;
    logic          read_dir;
    logic          next_read_dir;
    logic          next_oe;
    logic          next_wr_en;
    logic [7:0]    next_wr_data;
    logic          next_wake;
    logic          tmo_en;
    logic          next_tmo_en;
    logic [TW-1:0] tmr;
    logic [TW-1:0] next_tmr;

    // Bit capture on the link's own clock
    tsc_link_capture u_link (
        .link_clk_i (serial_clock_pin_i),
        .rst_n_i    (rst_n_i),
        .sda_i      (sda_i),
        .bit_o      (link_bit),
        .toggle_o   (link_tgl)
    );

    // Pins and bit toggle into the system domain
    tsc_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({serial_clock_pin_i, sda_i, link_tgl}),
        .sync_o  ({scl_s, sda_s, tgl_s})
    );

    // Edge detection, 50 MHz oversamples any legal bit rate
    always_comb begin
        start_ev  = scl_s & scl_d & sda_d & ~sda_s;
        stop_ev   = scl_s & scl_d & ~sda_d & sda_s;
        scl_fall  = scl_d & ~scl_s;
        bit_ev    = tgl_s ^ tgl_d;
        full_byte = {shreg[6:0], link_bit};
    end

    // Clock-low and bus-idle timers
    always_comb begin
        next_tmo_en = timeout_enable_i;
        if ((scl_s ^ scl_d) | (sda_s ^ sda_d)) begin
            next_tmr = '0;
        end else if (tmr == TW'(TMR_MAX)) begin
            next_tmr = tmr;
        end else begin
            next_tmr = tmr + TW'(1);
        end
        bus_reset = tmo_en & ((~scl_s & (tmr == TW'(TIMEOUT_CYCLES)))
                    | (scl_s & sda_s & (tmr == TW'(IDLE_CYCLES + 1))));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Same level as the synchroniser reset, so no false edge
            scl_d  <= 1'b0;
            sda_d  <= 1'b0;
            tgl_d  <= 1'b0;
            tmo_en <= 1'b0;
            tmr    <= '0;
        end else begin
            scl_d  <= scl_s;
            sda_d  <= sda_s;
            tgl_d  <= tgl_s;
            tmo_en <= next_tmo_en;
            tmr    <= next_tmr;
        end
    end

    // Protocol sequencer
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_shreg    = shreg;
        next_tx       = tx;
        next_ptr      = reg_addr_o;
        next_read_dir = read_dir;
        next_oe       = sda_oe_o;
        next_wr_en    = 1'b0;
        next_wr_data  = wr_data_o;
        if (bit_ev) begin
            next_shreg = full_byte;
        end
        case (state)
            TSC_ADDR: begin
                if (bit_ev) begin
                    next_cnt = cnt + 3'h1;
                    if (cnt == TSC_BIT_LAST) begin
                        if (full_byte[7:1] == TSC_OWN_ADDR) begin
                            next_read_dir = full_byte[0];
                            next_state    = TSC_ADDR_ACK;
                        end else begin
                            next_state = TSC_IGNORE;
                        end
                    end
                end
            end
            TSC_ADDR_ACK: begin
                if (scl_fall) begin
                    if (!sda_oe_o) begin
                        next_oe = 1'b1;
                    end else if (read_dir) begin
                        next_tx    = rd_data_i;
                        next_oe    = ~rd_data_i[7];
                        next_cnt   = '0;
                        next_state = TSC_RDATA;
                    end else begin
                        next_oe    = 1'b0;
                        next_cnt   = '0;
                        next_state = TSC_INDEX;
                    end
                end
            end
            TSC_INDEX: begin
                if (bit_ev) begin
                    next_cnt = cnt + 3'h1;
                    if (cnt == TSC_BIT_LAST) begin
                        next_ptr   = full_byte;
                        next_state = TSC_INDEX_ACK;
                    end
                end
            end
            TSC_INDEX_ACK: begin
                if (scl_fall) begin
                    if (!sda_oe_o) begin
                        next_oe = 1'b1;
                    end else begin
                        next_oe    = 1'b0;
                        next_cnt   = '0;
                        next_state = TSC_WDATA;
                    end
                end
            end
            TSC_WDATA: begin
                if (bit_ev) begin
                    next_cnt = cnt + 3'h1;
                    if (cnt == TSC_BIT_LAST) begin
                        next_wr_en   = 1'b1;
                        next_wr_data = full_byte;
                        next_state   = TSC_WDATA_ACK;
                    end
                end
            end
            TSC_WDATA_ACK: begin
                if (scl_fall) begin
                    if (!sda_oe_o) begin
                        next_oe = 1'b1;
                    end else begin
                        next_oe    = 1'b0;
                        next_ptr   = reg_addr_o + 8'h01;
                        next_cnt   = '0;
                        next_state = TSC_WDATA;
                    end
                end
            end
            TSC_RLOAD: begin
                if (scl_fall) begin
                    next_tx    = rd_data_i;
                    next_oe    = ~rd_data_i[7];
                    next_cnt   = '0;
                    next_state = TSC_RDATA;
                end
            end
            TSC_RDATA: begin
                if (bit_ev) begin
                    next_cnt = cnt + 3'h1;
                    if (cnt == TSC_BIT_LAST) begin
                        next_state = TSC_RDATA_ACK;
                    end
                end else if (scl_fall) begin
                    next_tx = {tx[6:0], 1'b0};
                    next_oe = ~tx[6];
                end
            end
            TSC_RDATA_ACK: begin
                if (scl_fall) begin
                    next_oe = 1'b0;
                end else if (bit_ev) begin
                    if (!link_bit) begin
                        next_ptr   = reg_addr_o + 8'h01;
                        next_state = TSC_RLOAD;
                    end else begin
                        next_state = TSC_IGNORE;
                    end
                end
            end
            default: begin
            end
        endcase
        if (bus_reset || stop_ev) begin
            next_state = TSC_IDLE;
            next_oe    = 1'b0;
        end else if (start_ev) begin
            next_state = TSC_ADDR;
            next_cnt   = '0;
            next_oe    = 1'b0;
        end
        // Pointer kept across sleep; pointer-only forms still served
        next_wake = (next_state != TSC_IDLE) && (next_state != TSC_IGNORE)
                    && (next_state != TSC_ADDR) && deep_sleep_control_i;
    end

    // Only the data line is ever driven; clock is input only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= TSC_IDLE;
            cnt        <= '0;
            shreg      <= '0;
            tx         <= '0;
            reg_addr_o <= TSC_PTR_RESET;
            read_dir   <= 1'b0;
            sda_oe_o   <= 1'b0;
            sda_o      <= 1'b0;
            wr_en_o    <= 1'b0;
            wr_data_o  <= '0;
            wake_o     <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            shreg      <= next_shreg;
            tx         <= next_tx;
            reg_addr_o <= next_ptr;
            read_dir   <= next_read_dir;
            sda_oe_o   <= next_oe;
            sda_o      <= 1'b0;
            wr_en_o    <= next_wr_en;
            wr_data_o  <= next_wr_data;
            wake_o     <= next_wake;
        end
    end
endmodule

// File: tsc_pkg.sv
// Shared constants and types of the touch sensor serial client
package tsc_pkg;

    // Own seven-bit client address
    localparam logic [6:0] TSC_OWN_ADDR  = 7'h28;

    // Register pointer value after reset
    localparam logic [7:0] TSC_PTR_RESET = 8'h00;

    // Bit counter value of the eighth bit of a byte
    localparam logic [2:0] TSC_BIT_LAST  = 3'h7;

    // System clock rate
    localparam int unsigned TSC_CLK_HZ = 50_000_000;

    // Clock-low timeout and bus-idle times
    localparam int unsigned TSC_SCL_LOW_TIMEOUT_MS = 30;
    localparam int unsigned TSC_BUS_IDLE_US        = 200;

    // Derived cycle counts
    localparam int unsigned TSC_SCL_LOW_TIMEOUT_CYC = TSC_CLK_HZ / 1000 * TSC_SCL_LOW_TIMEOUT_MS;
    localparam int unsigned TSC_BUS_IDLE_CYC        = TSC_CLK_HZ / 1_000_000 * TSC_BUS_IDLE_US;

    typedef enum logic [3:0] {
        TSC_IDLE,
        TSC_ADDR,
        TSC_ADDR_ACK,
        TSC_INDEX,
        TSC_INDEX_ACK,
        TSC_WDATA,
        TSC_WDATA_ACK,
        TSC_RLOAD,
        TSC_RDATA,
        TSC_RDATA_ACK,
        TSC_IGNORE
    } tsc_state_type;

endpackage

// File: tsc_sync.sv
// Two-flop level synchroniser into the system clock domain
module tsc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_stage1 = async_i;
        next_sync   = stage1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule

// File: tsc_link_capture.sv
// Data bit capture on the serial clock, with a toggle per bit
module tsc_link_capture (
    input  wire logic link_clk_i,
    input  wire logic rst_n_i,
    input  wire logic sda_i,
    output logic      bit_o,
    output logic      toggle_o
);
    logic next_bit;
    logic next_toggle;

    // Bit is held stable until the next rising clock edge
    always_comb begin
        next_bit    = sda_i;
        next_toggle = ~toggle_o;
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_o    <= 1'b0;
            toggle_o <= 1'b0;
        end else begin
            bit_o    <= next_bit;
            toggle_o <= next_toggle;
        end
    end
endmodule

// File: tsc_client_properties.sv
// Checker of the touch sensor serial client port behaviour
module tsc_client_properties
    import tsc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TSC_SCL_LOW_TIMEOUT_CYC,
    parameter int unsigned IDLE_CYCLES    = TSC_BUS_IDLE_CYC
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       serial_clock_pin_i,
    input wire logic       sda_i,
    input wire logic       timeout_enable_i,
    input wire logic       deep_sleep_control_i,
    input wire logic [7:0] rd_data_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       wr_en_o,
    input wire logic [7:0] reg_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic       wake_o
);
    logic [31:0] lo_cnt;
    logic        sda_q;
    // Cycles of quiet low clock with the timeout on
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_cnt <= '0;
            sda_q  <= 1'b1;
        end else begin
            sda_q  <= sda_i;
            lo_cnt <= (serial_clock_pin_i || !timeout_enable_i || sda_i != sda_q) ? '0 : lo_cnt + 1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_sda_o_zero; sda_o == 1'b0; endproperty
    a_sda_o_zero: assert property (p_sda_o_zero) else $error("data output not low");
    property p_wr_pulse; wr_en_o |=> !wr_en_o; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_wr_data_held; !wr_en_o |-> $stable(wr_data_o); endproperty
    a_wr_data_held: assert property (p_wr_data_held) else $error("write data moved");
    property p_ptr_held; wr_en_o |=> $stable(reg_addr_o) [*8]; endproperty
    a_ptr_held: assert property (p_ptr_held) else $error("pointer moved at write");
    property p_oe_low; $changed(sda_oe_o) |-> !serial_clock_pin_i; endproperty
    a_oe_low: assert property (p_oe_low) else $error("data changed with clock high");
    property p_wake; wake_o |-> deep_sleep_control_i; endproperty
    a_wake: assert property (p_wake) else $error("wake outside sleep");
    property p_timeout; lo_cnt > TIMEOUT_CYCLES + 8 |-> !sda_oe_o; endproperty
    a_timeout: assert property (p_timeout) else $error("data held past timeout");
    property p_wr_ack; $rose(wr_en_o) |-> ##[1:100] sda_oe_o; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("no ack after write");
endmodule

bind tsc_client tsc_client_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .IDLE_CYCLES(IDLE_CYCLES))
    i_tsc_client_properties (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clock_pin_i(serial_clock_pin_i),
    .sda_i(sda_i), .timeout_enable_i(timeout_enable_i), .deep_sleep_control_i(deep_sleep_control_i),
    .rd_data_i(rd_data_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_en_o(wr_en_o),
    .reg_addr_o(reg_addr_o), .wr_data_o(wr_data_o), .wake_o(wake_o));

// File: tsc_host.sv
// Two-wire host model driving the serial clock and data lines
module tsc_host (
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 640;
    int unsigned stretch;
    int unsigned hold;
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
        stretch   = 0;
        hold      = 0;
    end
    task bit_out(input logic b, output logic s);
        sda_low_o = !b;
        #Q scl_o = 1'b1;
        #(Q + hold) s = sda_i;
        #Q scl_o = 1'b0;
        #(Q + stretch);
    endtask
    task start;
        sda_low_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task stop;
        sda_low_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b0;
        #Q;
    endtask
    task wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(d[i], s);
        bit_out(1'b1, ack);
    endtask
    task rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(1'b1, d[i]);
        bit_out(last, s);
    endtask
endmodule

// File: tsc_client_test.sv
// Testbench of the touch sensor serial client
module tsc_client_test
    import tsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst_n, tmo_en, deep_sleep_control, scl, host_low, sda_o, sda_oe, wr_en, wake;
    logic [7:0] reg_addr, wr_data, wr_cnt;
    logic [7:0] regs  [256];
    logic [7:0] exp_v [256];
    int         error_cnt, checks;
    wire        sda_w;
    assign sda_w = !(host_low || (sda_oe && !sda_o));
    tsc_host i_tsc_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));
    tsc_client #(.TIMEOUT_CYCLES(200), .IDLE_CYCLES(300)) i_tsc_client (.clk_i(clk), .rst_n_i(rst_n),
        .serial_clock_pin_i(scl), .sda_i(sda_w), .timeout_enable_i(tmo_en), .deep_sleep_control_i(deep_sleep_control),
        .rd_data_i(regs[reg_addr]), .sda_o(sda_o), .sda_oe_o(sda_oe), .wr_en_o(wr_en),
        .reg_addr_o(reg_addr), .wr_data_o(wr_data), .wake_o(wake));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (wr_en === 1'b1) begin
            regs[reg_addr] <= wr_data;
            wr_cnt <= wr_cnt + 8'h01;
        end
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    task wr(input logic [7:0] idx, input int n, input logic [7:0] d);
        logic a;
        i_tsc_host.start();
        i_tsc_host.wbyte({TSC_OWN_ADDR, 1'b0}, a);
        chk("ack_addr", 8'h00, {7'h00, a});
        i_tsc_host.wbyte(idx, a);
        chk("ack_idx", 8'h00, {7'h00, a});
        for (int k = 0; k < n; k++) begin
            i_tsc_host.wbyte(d + 8'(k), a);
            chk("ack_data", 8'h00, {7'h00, a});
            exp_v[idx + 8'(k)] = d + 8'(k);
        end
        i_tsc_host.stop();
    endtask
    task rd(input logic [7:0] idx, input logic set, input int n);
        logic       a;
        logic [7:0] v;
        if (set) begin
            i_tsc_host.start();
            i_tsc_host.wbyte({TSC_OWN_ADDR, 1'b0}, a);
            i_tsc_host.wbyte(idx, a);
        end
        i_tsc_host.start();
        i_tsc_host.wbyte({TSC_OWN_ADDR, 1'b1}, a);
        chk("ack_rd", 8'h00, {7'h00, a});
        for (int k = 0; k < n; k++) begin
            i_tsc_host.rbyte(k == n - 1, v);
            chk("rd_data", exp_v[idx + 8'(k)], v);
        end
        i_tsc_host.stop();
    endtask
    task t_write_read;
        wr(8'h10, 1, 8'hAB);
        chk("reg10", 8'hAB, regs[8'h10]);
        rd(8'h10, 1, 1);
    endtask
    task t_block_wrap;
        wr(8'hFE, 3, 8'hC1);
        chk("reg00", 8'hC3, regs[8'h00]);
        rd(8'hFE, 1, 3);
    endtask
    task t_pointer;
        i_tsc_host.stretch = 3000;
        wr(8'h33, 0, 8'h00);
        rd(8'h33, 0, 1);
        rd(8'h33, 0, 1);
        i_tsc_host.stretch = 0;
    endtask
    task t_foreign;
        logic       a;
        logic [7:0] w0;
        w0 = wr_cnt;
        i_tsc_host.start();
        i_tsc_host.wbyte({TSC_OWN_ADDR ^ 7'h01, 1'b0}, a);
        chk("ack_foreign", 8'h01, {7'h00, a});
        i_tsc_host.wbyte(8'h40, a);
        chk("ack_ignored", 8'h01, {7'h00, a});
        i_tsc_host.stop();
        chk("wr_cnt", w0, wr_cnt);
    endtask
    task t_sleep;
        @(negedge clk);
        deep_sleep_control = 1'b1;
        fork
            wr(8'h05, 1, 8'h77);
            begin
                #30000;
                chk("wake_on", 8'h01, {7'h00, wake});
            end
        join
        repeat (20) @(negedge clk);
        chk("wake_off", 8'h00, {7'h00, wake});
        rd(8'h05, 1, 1);
        @(negedge clk);
        deep_sleep_control = 1'b0;
    endtask
    task t_timeout(input logic en);
        logic       s;
        logic [7:0] aw;
        aw = {TSC_OWN_ADDR, 1'b0};
        @(negedge clk);
        tmo_en = en;
        i_tsc_host.start();
        for (int i = 7; i >= 0; i--) i_tsc_host.bit_out(aw[i], s);
        repeat (400) @(negedge clk);
        chk("ack_drive", {7'h00, !en}, {7'h00, sda_oe});
        i_tsc_host.bit_out(1'b1, s);
        chk("ack_late", {7'h00, en}, {7'h00, s});
        i_tsc_host.stop();
        @(negedge clk);
        tmo_en = 1'b0;
    endtask
    task t_idle;
        logic       a;
        logic [7:0] d;
        d = 8'hC4;
        @(negedge clk);
        tmo_en = 1'b1;
        i_tsc_host.start();
        i_tsc_host.wbyte({TSC_OWN_ADDR, 1'b0}, a);
        i_tsc_host.hold = 8000;
        i_tsc_host.bit_out(d[7], a);
        i_tsc_host.hold = 0;
        for (int i = 6; i >= 0; i--) i_tsc_host.bit_out(d[i], a);
        i_tsc_host.bit_out(1'b1, a);
        chk("ack_idle", 8'h01, {7'h00, a});
        i_tsc_host.stop();
        @(negedge clk);
        tmo_en = 1'b0;
    endtask
    task test_done;
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        tmo_en = 1'b0;
        deep_sleep_control = 1'b0;
        wr_cnt = 8'h00;
        error_cnt = 0;
        checks = 0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5A;
            exp_v[i] = 8'(i) ^ 8'h5A;
        end
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_write_read();
        t_block_wrap();
        t_pointer();
        t_foreign();
        t_sleep();
        t_timeout(1'b0);
        t_timeout(1'b1);
        t_idle();
        test_done();
    end
endmodule
